/* File: mesb_pkg.sv */
// Constants and types shared by the metering event status bank.
// Assumes a single 20 MHz clock and an external serial front end.
package mesb_pkg;

  // ************************************************************
  // Widths and timing
  // ************************************************************
  localparam int MESB_AW = 7;
  localparam int MESB_DW = 16;
  localparam int MESB_CLK_HZ = 20000000;
  // Internal reset stretch after a software reset is one clock cycle more than this
  localparam logic [3:0] MESB_SWRST_HOLD = 4'h4;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [MESB_AW-1:0] MESB_OFS_SWRST   = 7'h70;
  localparam logic [MESB_AW-1:0] MESB_OFS_STATE0  = 7'h71;
  localparam logic [MESB_AW-1:0] MESB_OFS_STATE1  = 7'h72;
  localparam logic [MESB_AW-1:0] MESB_OFS_FLAGS0  = 7'h73;
  localparam logic [MESB_AW-1:0] MESB_OFS_FLAGS1  = 7'h74;
  localparam logic [MESB_AW-1:0] MESB_OFS_MASK0   = 7'h75;
  localparam logic [MESB_AW-1:0] MESB_OFS_MASK1   = 7'h76;
  localparam logic [MESB_AW-1:0] MESB_OFS_LASTXF  = 7'h78;
  localparam logic [MESB_AW-1:0] MESB_OFS_CKFAULT = 7'h79;
  localparam logic [MESB_AW-1:0] MESB_OFS_CKVALUE = 7'h7a;
  localparam logic [MESB_AW-1:0] MESB_OFS_UNLOCK  = 7'h7f;

  // ************************************************************
  // Values
  // ************************************************************
  localparam logic [MESB_DW-1:0] MESB_SWRST_KEY = 16'h789a;
  localparam logic [MESB_DW-1:0] MESB_RST_VAL   = 16'h0000;
  localparam logic [MESB_DW-1:0] MESB_RD_ZERO   = 16'h0000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [0:0] {
    MESB_RG_IDLE = 1'b0,
    MESB_RG_HOLD = 1'b1
  } mesb_rg_e;

  typedef struct packed {
    mesb_rg_e   st;
    logic [3:0] cnt;
    logic       coreRstN;
  } mesb_rg_s;

  typedef struct packed {
    logic [MESB_DW-1:0] statePri;
    logic [MESB_DW-1:0] stateSec;
    logic [MESB_DW-1:0] flagsPri;
    logic [MESB_DW-1:0] flagsSec;
    logic [MESB_DW-1:0] maskPri;
    logic [MESB_DW-1:0] maskSec;
    logic [MESB_DW-1:0] lastXfer;
    logic [MESB_DW-1:0] ckValue;
    logic [MESB_DW-1:0] unlock;
    logic [MESB_DW-1:0] rdData;
    logic               irq;
    logic               swReq;
  } mesb_bank_s;

endpackage : mesb_pkg

/* File: mesb_rst_if.sv */
// Reset request and core reset carried between bank and reset stretcher.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface mesb_rst_if;
  logic swResetReq;
  logic coreRstN;

  modport ctl (output swResetReq, input coreRstN);
  modport gen (input swResetReq, output coreRstN);
endinterface : mesb_rst_if

/* File: mesb_reset_gen.sv */
// Core reset generator: merges the reset pin with software reset requests.
// Assumes resetn is asynchronous; release of the core reset is synchronous.
`timescale 1ns/1ns
module mesb_reset_gen
  import mesb_pkg::*;
(
  input logic  mclk,
  input logic  resetn,
  mesb_rst_if.gen rst
);

  mesb_rg_s rg_r;
  mesb_rg_s rg_nxt;

  // ************************************************************
  // Stretch a request into a multi-cycle core reset
  // ************************************************************
  always_comb begin
    rg_nxt = rg_r;
    unique case (rg_r.st)
      MESB_RG_IDLE: begin
        rg_nxt.coreRstN = 1'b1;
        if (rg_r.coreRstN && rst.swResetReq) begin
          rg_nxt.st       = MESB_RG_HOLD;
          rg_nxt.cnt      = MESB_SWRST_HOLD - 4'h1;
          rg_nxt.coreRstN = 1'b0;
        end
      end
      MESB_RG_HOLD: begin
        rg_nxt.coreRstN = 1'b0;
        if (rg_r.cnt == 4'h0) begin
          rg_nxt.st = MESB_RG_IDLE;
        end else begin
          rg_nxt.cnt = rg_r.cnt - 4'h1;
        end
      end
    endcase
  end

  // Only the pin clears this; the core reset must not reset itself
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rg_r <= '{st: MESB_RG_IDLE, cnt: 4'h0, coreRstN: 1'b0};
    end else begin
      rg_r <= rg_nxt;
    end
  end

  assign rst.coreRstN = rg_r.coreRstN;

endmodule : mesb_reset_gen

/* File: mesb_status_bank.sv */
// Event state, change flags, masks and housekeeping registers of the meter.
// Assumes a serial front end presents one register access per strobe.
//
// What this block does
// RL1: Writing 789AH to register 70H resets the device.
// RL2: Software reset hits the same logic as pin or power-on reset.
// RL3: Reading the software reset register always returns zero.
// RL4: Primary state bits 15..13 show over-current on phases A..C.
// RL5: Primary state bits 12..10 show over-voltage on phases A..C.
// RL6: Bit 9 voltage sequence error, bit 8 current sequence error.
// RL7: Bit 7 set when neutral current exceeds warning threshold.
// RL8: Bits 6..4 show reactive, active, apparent sum no-load.
// RL9: Bits 3..0 give pulse outputs 1..4 direction, 1 reverse.
// RL10: Secondary bit 15 frequency high, bit 11 frequency low.
// RL11: Secondary bits 14..12 show sag on phases A..C.
// RL12: Secondary bits 10..8 show phase loss on phases A..C.
// RL13: Bit 7 total reactive sign, bits 6..4 phases A..C, 1 negative.
// RL14: Bit 3 total active sign, bits 2..0 phases A..C, 1 negative.
// RL15: Flag registers 73H and 74H readable, cleared bitwise by writing one.
// RL16: Mask registers 75H and 76H are plain read/write storage.
// RL17: Register 78H holds the last transfer value, write-one clears.
// RL18: A flag sets whenever its state bit changes value.
// RL19: A set flag interrupts only when its mask bit is one.
// RL20: Interrupt stays high while any unmasked flag remains set.
// RL21: State bits are live, ignore writes, read zero after reset.
`timescale 1ns/1ns
module mesb_status_bank
  import mesb_pkg::*;
#(
  parameter int NEUTRAL_W = 16
) (
  input  logic                 mclk,
  input  logic                 resetn,
  // Register access from the serial front end
  input  logic [MESB_AW-1:0]   regAddr,
  input  logic [MESB_DW-1:0]   regWrData,
  input  logic                 regWr,
  input  logic                 regRd,
  output logic [MESB_DW-1:0]   regRdData,
  // Detector levels, primary group
  input  logic                 overcurrentAState,
  input  logic                 overcurrentBState,
  input  logic                 overcurrentCState,
  input  logic                 overvoltageAState,
  input  logic                 overvoltageBState,
  input  logic                 overvoltageCState,
  input  logic                 voltageSequenceError,
  input  logic                 currentSequenceError,
  input  logic [NEUTRAL_W-1:0] neutralCurrent,
  input  logic [NEUTRAL_W-1:0] neutralWarningThreshold,
  input  logic                 totalReactiveNoload,
  input  logic                 totalActiveNoload,
  input  logic                 totalApparentNoload,
  input  logic                 pulseOut1Reverse,
  input  logic                 pulseOut2Reverse,
  input  logic                 pulseOut3Reverse,
  input  logic                 pulseOut4Reverse,
  // Detector levels, secondary group
  input  logic                 frequencyAboveLimit,
  input  logic                 frequencyBelowLimit,
  input  logic                 sagAState,
  input  logic                 sagBState,
  input  logic                 sagCState,
  input  logic                 lossAState,
  input  logic                 lossBState,
  input  logic                 lossCState,
  input  logic                 reactiveTotalSign,
  input  logic                 reactiveASign,
  input  logic                 reactiveBSign,
  input  logic                 reactiveCSign,
  input  logic                 activeTotalSign,
  input  logic                 activeASign,
  input  logic                 activeBSign,
  input  logic                 activeCSign,
  // Checksum block and configuration
  input  logic [MESB_DW-1:0]   checksumFaultState,
  output logic [MESB_DW-1:0]   checksumValue,
  output logic [MESB_DW-1:0]   configWriteUnlock,
  output logic                 irqOut
);

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic hit(
    input logic [MESB_AW-1:0] addr,
    input logic [MESB_AW-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction : hit

  // ************************************************************
  // Core reset
  // ************************************************************
  mesb_rst_if rstLink ();

  mesb_reset_gen uResetGen (
    .mclk   (mclk),
    .resetn (resetn),
    .rst    (rstLink.gen)
  );

  logic coreRstN;
  assign coreRstN = rstLink.coreRstN;

  // ************************************************************
  // Detector sampling
  // ************************************************************
  logic               neutralOver;
  logic [MESB_DW-1:0] sampPri;
  logic [MESB_DW-1:0] sampSec;

  assign neutralOver = (neutralCurrent > neutralWarningThreshold); // [RL7]

  assign sampPri = {
    overcurrentAState,    // [RL4]
    overcurrentBState,
    overcurrentCState,
    overvoltageAState,    // [RL5]
    overvoltageBState,
    overvoltageCState,
    voltageSequenceError, // [RL6]
    currentSequenceError,
    neutralOver,          // [RL7]
    totalReactiveNoload,  // [RL8]
    totalActiveNoload,
    totalApparentNoload,
    pulseOut1Reverse,     // [RL9]
    pulseOut2Reverse,
    pulseOut3Reverse,
    pulseOut4Reverse
  };

  assign sampSec = {
    frequencyAboveLimit,  // [RL10]
    sagAState,            // [RL11]
    sagBState,
    sagCState,
    frequencyBelowLimit,  // [RL10]
    lossAState,           // [RL12]
    lossBState,
    lossCState,
    reactiveTotalSign,    // [RL13]
    reactiveASign,
    reactiveBSign,
    reactiveCSign,
    activeTotalSign,      // [RL14]
    activeASign,
    activeBSign,
    activeCSign
  };

  // ************************************************************
  // Register state
  // ************************************************************
  mesb_bank_s bk_r;
  mesb_bank_s bk_nxt;

  logic               wrSwRst;
  logic               wrFlags0;
  logic               wrFlags1;
  logic               wrMask0;
  logic               wrMask1;
  logic               wrLastXf;
  logic               wrCkValue;
  logic               wrUnlock;
  logic [MESB_DW-1:0] rdMux;
  logic [MESB_DW-1:0] clrPri;
  logic [MESB_DW-1:0] clrSec;
  logic [MESB_DW-1:0] chgPri;
  logic [MESB_DW-1:0] chgSec;

  assign wrSwRst   = regWr && hit(regAddr, MESB_OFS_SWRST);
  assign wrFlags0  = regWr && hit(regAddr, MESB_OFS_FLAGS0);
  assign wrFlags1  = regWr && hit(regAddr, MESB_OFS_FLAGS1);
  assign wrMask0   = regWr && hit(regAddr, MESB_OFS_MASK0);
  assign wrMask1   = regWr && hit(regAddr, MESB_OFS_MASK1);
  assign wrLastXf  = regWr && hit(regAddr, MESB_OFS_LASTXF);
  assign wrCkValue = regWr && hit(regAddr, MESB_OFS_CKVALUE);
  assign wrUnlock  = regWr && hit(regAddr, MESB_OFS_UNLOCK);

  // Edges of the sampled levels against the value software sees
  assign chgPri = sampPri ^ bk_r.statePri; // [RL18]
  assign chgSec = sampSec ^ bk_r.stateSec; // [RL18]

  assign clrPri = wrFlags0 ? regWrData : MESB_RD_ZERO; // [RL15]
  assign clrSec = wrFlags1 ? regWrData : MESB_RD_ZERO; // [RL15]

  // ************************************************************
  // Read multiplexer
  // ************************************************************
  always_comb begin
    unique case (regAddr)
      MESB_OFS_SWRST:   rdMux = MESB_RD_ZERO; // [RL3]
      MESB_OFS_STATE0:  rdMux = bk_r.statePri;
      MESB_OFS_STATE1:  rdMux = bk_r.stateSec;
      MESB_OFS_FLAGS0:  rdMux = bk_r.flagsPri; // [RL15]
      MESB_OFS_FLAGS1:  rdMux = bk_r.flagsSec; // [RL15]
      MESB_OFS_MASK0:   rdMux = bk_r.maskPri;  // [RL16]
      MESB_OFS_MASK1:   rdMux = bk_r.maskSec;  // [RL16]
      MESB_OFS_LASTXF:  rdMux = bk_r.lastXfer;
      MESB_OFS_CKFAULT: rdMux = checksumFaultState;
      MESB_OFS_CKVALUE: rdMux = bk_r.ckValue;
      MESB_OFS_UNLOCK:  rdMux = bk_r.unlock;
      default:          rdMux = MESB_RD_ZERO;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    bk_nxt = bk_r;

    // Live view; nothing written by software lands here
    bk_nxt.statePri = sampPri; // [RL21]
    bk_nxt.stateSec = sampSec; // [RL21]

    // A change in the clearing cycle survives the clear
    bk_nxt.flagsPri = (bk_r.flagsPri & ~clrPri) | chgPri; // [RL15] [RL18]
    bk_nxt.flagsSec = (bk_r.flagsSec & ~clrSec) | chgSec; // [RL15] [RL18]

    if (wrMask0) begin
      bk_nxt.maskPri = regWrData; // [RL16]
    end
    if (wrMask1) begin
      bk_nxt.maskSec = regWrData; // [RL16]
    end
    if (wrCkValue) begin
      bk_nxt.ckValue = regWrData;
    end
    if (wrUnlock) begin
      bk_nxt.unlock = regWrData;
    end

    // Clearing write to 78H is not itself recorded, else it could never clear
    if (wrLastXf) begin
      bk_nxt.lastXfer = bk_r.lastXfer & ~regWrData; // [RL17]
    end else if (regWr) begin
      bk_nxt.lastXfer = regWrData; // [RL17]
    end else if (regRd) begin
      bk_nxt.lastXfer = rdMux; // [RL17]
    end

    if (regRd) begin
      bk_nxt.rdData = rdMux;
    end

    // Key must match exactly; other values are dropped
    bk_nxt.swReq = wrSwRst && (regWrData == MESB_SWRST_KEY); // [RL1]

    bk_nxt.irq = |({bk_nxt.flagsPri, bk_nxt.flagsSec} &
                   {bk_nxt.maskPri, bk_nxt.maskSec}); // [RL19] [RL20]
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Core reset covers pin and software reset alike
  always_ff @(posedge mclk or negedge coreRstN) begin
    if (!coreRstN) begin
      bk_r <= '{
        statePri: MESB_RST_VAL, // [RL21]
        stateSec: MESB_RST_VAL,
        flagsPri: MESB_RST_VAL,
        flagsSec: MESB_RST_VAL,
        maskPri:  MESB_RST_VAL,
        maskSec:  MESB_RST_VAL,
        lastXfer: MESB_RST_VAL,
        ckValue:  MESB_RST_VAL,
        unlock:   MESB_RST_VAL,
        rdData:   MESB_RST_VAL,
        irq:      1'b0,
        swReq:    1'b0
      }; // [RL2]
    end else begin
      bk_r <= bk_nxt;
    end
  end

  assign rstLink.swResetReq = bk_r.swReq; // [RL1] [RL2]

  // ************************************************************
  // Outputs
  // ************************************************************
  assign regRdData         = bk_r.rdData;
  assign checksumValue     = bk_r.ckValue;
  assign configWriteUnlock = bk_r.unlock;
  assign irqOut            = bk_r.irq;

endmodule : mesb_status_bank

/* File: mesb_status_bank_checker.sv */
// Port checker for the status bank, bound to its top module.
// Assumes one mclk domain and the software reset stretch of the package.
`timescale 1ns/1ns
module mesb_status_bank_checker
  import mesb_pkg::*;
#(
  parameter int NEUTRAL_W = 16
) (
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic [MESB_AW-1:0]   regAddr,
  input wire logic [MESB_DW-1:0]   regWrData,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire logic [MESB_DW-1:0]   regRdData,
  input wire logic                 overcurrentAState,
  input wire logic                 sagAState,
  input wire logic [NEUTRAL_W-1:0] neutralCurrent,
  input wire logic [NEUTRAL_W-1:0] neutralWarningThreshold,
  input wire logic [MESB_DW-1:0]   checksumValue,
  input wire logic [MESB_DW-1:0]   configWriteUnlock,
  input wire logic                 irqOut
);
  // ************************************************************
  // Helper state
  // ************************************************************
  logic [3:0]         swCnt_r;
  logic [MESB_DW-1:0] maskPri_r;
  logic [MESB_DW-1:0] maskSec_r;
  logic               keyWr;

  assign keyWr = regWr && regAddr == MESB_OFS_SWRST && regWrData == MESB_SWRST_KEY;

  // Blanks checks for the whole reset stretch, release time is only rough
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      swCnt_r   <= 4'h0;
      maskPri_r <= MESB_RST_VAL;
      maskSec_r <= MESB_RST_VAL;
    end else if (keyWr || swCnt_r != 4'h0) begin
      swCnt_r   <= keyWr ? 4'h9 : swCnt_r - 4'h1;
      maskPri_r <= MESB_RST_VAL;
      maskSec_r <= MESB_RST_VAL;
    end else if (regWr && regAddr == MESB_OFS_MASK0) begin
      maskPri_r <= regWrData;
    end else if (regWr && regAddr == MESB_OFS_MASK1) begin
      maskSec_r <= regWrData;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn || swCnt_r != 4'h0);

  sequence wrAt(logic [MESB_AW-1:0] a);
    regWr && regAddr == a;
  endsequence
  sequence rdAt(logic [MESB_AW-1:0] a);
    regRd && !regWr && regAddr == a;
  endsequence

  swrst_read_zero_a: assert property (
    rdAt(MESB_OFS_SWRST) |=> regRdData == MESB_RD_ZERO) else $error("reset reg read nonzero");
  mask_readback_a: assert property (
    wrAt(MESB_OFS_MASK0) ##2 rdAt(MESB_OFS_MASK0) |=> regRdData == $past(regWrData, 3))
    else $error("mask readback differs");
  ovc_state_a: assert property (
    rdAt(MESB_OFS_STATE0) |=> regRdData[15] == $past(overcurrentAState, 2))
    else $error("overcurrent state bit wrong");
  neutral_cmp_a: assert property (
    rdAt(MESB_OFS_STATE0) |=> regRdData[7] ==
      ($past(neutralCurrent, 2) > $past(neutralWarningThreshold, 2)))
    else $error("neutral state bit wrong");
  sag_state_a: assert property (
    rdAt(MESB_OFS_STATE1) |=> regRdData[14] == $past(sagAState, 2))
    else $error("sag state bit wrong");
  irq_masked_a: assert property (
    maskPri_r == MESB_RST_VAL && maskSec_r == MESB_RST_VAL |-> !irqOut)
    else $error("interrupt with all masks clear");
  last_xfer_a: assert property (
    regWr && regAddr != MESB_OFS_LASTXF && regAddr != MESB_OFS_SWRST
      ##2 rdAt(MESB_OFS_LASTXF) |=> regRdData == $past(regWrData, 3))
    else $error("last transfer not captured");
  sw_reset_a: assert property (disable iff (!resetn)
    keyWr |-> ##4 (checksumValue == MESB_RST_VAL && configWriteUnlock == MESB_RST_VAL
      && !irqOut)) else $error("software reset left outputs set");
endmodule : mesb_status_bank_checker

bind mesb_status_bank mesb_status_bank_checker #(.NEUTRAL_W(NEUTRAL_W))
  mesb_status_bank_checker_i (.mclk, .resetn, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .overcurrentAState, .sagAState, .neutralCurrent, .neutralWarningThreshold,
  .checksumValue, .configWriteUnlock, .irqOut);

/* File: mesb_detector_model.sv */
// Detector front end model: turns bench commands into detector levels.
// Assumes commands change just after a rising edge of mclk.
`timescale 1ns/1ns
module mesb_detector_model
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [15:0] priCmd,
  input  wire logic [15:0] secCmd,
  output logic      [15:0] priLvl,
  output logic      [15:0] secLvl,
  output logic      [15:0] neutralLvl
);
  // Primary bit 7 becomes a neutral current one above threshold 4, else equal to it
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      priLvl     <= 16'h0000;
      secLvl     <= 16'h0000;
      neutralLvl <= 16'h0004;
    end else begin
      priLvl     <= priCmd;
      secLvl     <= secCmd;
      neutralLvl <= priCmd[7] ? 16'h0005 : 16'h0004;
    end
  end
endmodule : mesb_detector_model

/* File: mesb_status_bank_tb.sv */
// Bench for the status bank: register accesses against detector stimulus.
// Assumes the detector model and the bound port checker.
`timescale 1ns/1ns
module mesb_status_bank_tb
  import mesb_pkg::*;
;
  logic               mclk;
  logic               resetn;
  logic [MESB_AW-1:0] regAddr;
  logic [MESB_DW-1:0] regWrData;
  logic               regWr;
  logic               regRd;
  logic [MESB_DW-1:0] regRdData;
  logic [MESB_DW-1:0] checksumValue;
  logic [MESB_DW-1:0] configWriteUnlock;
  logic               irqOut;
  logic [MESB_DW-1:0] priCmd;
  logic [MESB_DW-1:0] secCmd;
  logic [MESB_DW-1:0] priLvl;
  logic [MESB_DW-1:0] secLvl;
  logic [MESB_DW-1:0] neutralLvl;
  logic [MESB_DW-1:0] neutralThr;
  int                 mismatches = 0;
  int                 checksDone = 0;

  mesb_detector_model mesb_detector_model_i (
    .mclk, .resetn, .priCmd, .secCmd, .priLvl, .secLvl, .neutralLvl
  );
  // Checksum fault tied: fault path has no rule here
  mesb_status_bank #(.NEUTRAL_W(16)) mesb_status_bank_i (
    .mclk, .resetn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .overcurrentAState(priLvl[15]), .overcurrentBState(priLvl[14]),
    .overcurrentCState(priLvl[13]), .overvoltageAState(priLvl[12]),
    .overvoltageBState(priLvl[11]), .overvoltageCState(priLvl[10]),
    .voltageSequenceError(priLvl[9]), .currentSequenceError(priLvl[8]),
    .neutralCurrent(neutralLvl), .neutralWarningThreshold(neutralThr),
    .totalReactiveNoload(priLvl[6]), .totalActiveNoload(priLvl[5]),
    .totalApparentNoload(priLvl[4]), .pulseOut1Reverse(priLvl[3]),
    .pulseOut2Reverse(priLvl[2]), .pulseOut3Reverse(priLvl[1]),
    .pulseOut4Reverse(priLvl[0]), .frequencyAboveLimit(secLvl[15]),
    .sagAState(secLvl[14]), .sagBState(secLvl[13]), .sagCState(secLvl[12]),
    .frequencyBelowLimit(secLvl[11]), .lossAState(secLvl[10]), .lossBState(secLvl[9]),
    .lossCState(secLvl[8]), .reactiveTotalSign(secLvl[7]), .reactiveASign(secLvl[6]),
    .reactiveBSign(secLvl[5]), .reactiveCSign(secLvl[4]), .activeTotalSign(secLvl[3]),
    .activeASign(secLvl[2]), .activeBSign(secLvl[1]), .activeCSign(secLvl[0]),
    .checksumFaultState(16'h0000), .checksumValue, .configWriteUnlock, .irqOut
  );

  always #25 mclk = ~mclk;

  // ************************************************************
  // Access and check tasks
  // ************************************************************
  task automatic chk(input logic [MESB_DW-1:0] got, input logic [MESB_DW-1:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; leaves an idle cycle behind each access
  task automatic acc(input logic w, input logic [MESB_AW-1:0] a,
                     input logic [MESB_DW-1:0] d, input logic [MESB_DW-1:0] e);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= w;
    regRd     <= !w;
    @(posedge mclk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(negedge mclk);
    if (!w) chk(regRdData, e);
    @(posedge mclk);
  endtask : acc

  task automatic wr(input logic [MESB_AW-1:0] a, input logic [MESB_DW-1:0] d);
    acc(1'b1, a, d, 16'h0000);
  endtask : wr

  task automatic rd(input logic [MESB_AW-1:0] a, input logic [MESB_DW-1:0] e);
    acc(1'b0, a, 16'h0000, e);
  endtask : rd

  task automatic irqChk(input logic e);
    @(negedge mclk);
    chk({15'h0000, irqOut}, {15'h0000, e});
    @(posedge mclk);
  endtask : irqChk

  task automatic printVerdict();
    $display("mismatches %0d, checks %0d", mismatches, checksDone);
    if (mismatches == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : printVerdict

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    mclk      = 1'b0;
    resetn    = 1'b0;
    regAddr   = '0;
    regWrData = '0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    priCmd    = '0;
    secCmd    = '0;
    neutralThr = 16'h0004;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int a = 32'h0000_0070; a < 32'h0000_0077; a++) rd(a[6:0], 16'h0000);
    wr(MESB_OFS_SWRST, 16'h1234);
    rd(MESB_OFS_SWRST, 16'h0000);
    wr(MESB_OFS_STATE0, 16'hffff);
    rd(MESB_OFS_STATE0, 16'h0000);
    wr(MESB_OFS_MASK0, 16'h5a5a);
    rd(MESB_OFS_MASK0, 16'h5a5a);
    rd(MESB_OFS_LASTXF, 16'h5a5a);
    wr(MESB_OFS_MASK1, 16'ha5a5);
    rd(MESB_OFS_MASK1, 16'ha5a5);
    wr(MESB_OFS_MASK0, 16'h0000);
    wr(MESB_OFS_MASK1, 16'h0000);
    // Walk one bit through both groups; flags see the rise and the previous fall
    for (int i = 0; i < 16; i++) begin
      priCmd <= 16'h0001 << i;
      secCmd <= 16'h0001 << i;
      repeat (3) @(posedge mclk);
      rd(MESB_OFS_STATE0, 16'h0001 << i);
      rd(MESB_OFS_STATE1, 16'h0001 << i);
      rd(MESB_OFS_FLAGS0, (16'h0001 << i) | ((16'h0001 << i) >> 1));
      rd(MESB_OFS_FLAGS1, (16'h0001 << i) | ((16'h0001 << i) >> 1));
      irqChk(1'b0);
      wr(MESB_OFS_FLAGS0, 16'hffff);
      wr(MESB_OFS_FLAGS1, 16'hffff);
    end
    priCmd <= 16'h0000;
    secCmd <= 16'h4000;
    repeat (3) @(posedge mclk);
    wr(MESB_OFS_FLAGS0, 16'hffff);
    rd(MESB_OFS_FLAGS0, 16'h0000);
    irqChk(1'b0);
    wr(MESB_OFS_MASK1, 16'h4000);
    irqChk(1'b1);
    wr(MESB_OFS_FLAGS1, 16'h0040);
    irqChk(1'b1);
    wr(MESB_OFS_FLAGS1, 16'h4000);
    irqChk(1'b0);
    rd(MESB_OFS_FLAGS1, 16'h8000);
    secCmd <= 16'h0000;
    repeat (3) @(posedge mclk);
    rd(MESB_OFS_FLAGS1, 16'hc000);
    irqChk(1'b1);
    // Equal to threshold must not set the neutral current warning bit
    priCmd     <= 16'h0080;
    neutralThr <= 16'h0005;
    repeat (3) @(posedge mclk);
    rd(MESB_OFS_STATE0, 16'h0000);
    neutralThr <= 16'h0004;
    repeat (3) @(posedge mclk);
    rd(MESB_OFS_STATE0, 16'h0080);
    priCmd <= 16'h0000;
    wr(MESB_OFS_CKVALUE, 16'habcd);
    rd(MESB_OFS_LASTXF, 16'habcd);
    wr(MESB_OFS_LASTXF, 16'hffff);
    rd(MESB_OFS_LASTXF, 16'h0000);
    wr(MESB_OFS_UNLOCK, 16'h1111);
    chk(configWriteUnlock, 16'h1111);
    wr(MESB_OFS_SWRST, MESB_SWRST_KEY);
    repeat (10) @(posedge mclk);
    chk(configWriteUnlock, 16'h0000);
    chk(checksumValue, 16'h0000);
    irqChk(1'b0);
    rd(MESB_OFS_MASK1, 16'h0000);
    printVerdict();
  end

  // Whole run is under a thousand cycles; this allows ample slack
  initial begin
    #200000;
    mismatches++;
    printVerdict();
  end
endmodule : mesb_status_bank_tb
